//--- common/pss_pkg.sv
// Package: constants and carrier types for the program sequencer and stack
package pss_pkg;
   localparam int PC_W = 10;
   localparam int PROG_DEPTH = 1002;
   localparam int DMEM_DEPTH = 32;
   localparam int DMEM_W = 5;
   localparam int DADDR_W = 5;
   localparam int SIDX_W = 2;
   localparam int ACC_W = 4;
   localparam int TPTR_LO_W = 8;
   localparam int TPTR_HI_W = 2;
   localparam logic [PC_W-1:0] PC_RESET = 10'h000;
   localparam logic [PC_W-1:0] CALL_SAVE_INC = 10'h001;
   localparam logic [PC_W-1:0] RET_INC = 10'h002;
   localparam logic [SIDX_W-1:0] SIDX_RESET = 2'h0;
   localparam logic [SIDX_W-1:0] SIDX_MAX = 2'h3;
   localparam logic [SIDX_W-1:0] SIDX_STEP = 2'h1;
   // Stack word for index 0; higher indices count downward
   localparam logic [DADDR_W-1:0] STACK_TOP_ADDR = 5'h0F;
   // Table pointer pair words (low nibble word, high nibble word)
   localparam logic [DADDR_W-1:0] TPTR_LOW_ADDR = 5'h00;
   localparam logic [DADDR_W-1:0] TPTR_HIGH_ADDR = 5'h01;

   typedef enum logic [2:0] {
      PSS_OP_NEXT,
      PSS_OP_JUMP,
      PSS_OP_JUMP_MEM,
      PSS_OP_CALL,
      PSS_OP_RETURN
   } pss_op_t;

   // One sequencing request from the decoder
   typedef struct packed {
      pss_op_t op;
      logic [1:0] length;
      logic [PC_W-1:0] target;
      logic [PC_W-1:0] load_mask;
      logic [DADDR_W-1:0] mem_addr;
      logic taken;
   } pss_seq_req_t;

   // One data-memory write request
   typedef struct packed {
      logic we;
      logic [DADDR_W-1:0] addr;
      logic [DMEM_W-1:0] data;
   } pss_dmem_wr_t;

   typedef struct packed {
      logic [PC_W-1:0] program_counter;
      logic [SIDX_W-1:0] stack_index;
      logic [ACC_W-1:0] acc;
      logic [PC_W-1:0] table_addr;
      logic [PC_W-1:0] instr;
      logic [PC_W-1:0] table_data;
      logic runaway;
   } pss_state_t;
endpackage

//--- src/pss_sequencer.sv
// Program sequencer with stack, program memory, data memory and accumulator
`timescale 1ns/1ps
// Contract
// [RULE1] Ten-bit program counter steps by the executed instruction's length.
// [RULE2] Taken jumps load masked counter bits from immediate or data memory.
// [RULE3] Call saves counter plus one onto the stack, then loads target.
// [RULE4] Return loads saved stack entry plus two into the counter.
// [RULE5] Reset or all-clear clears the program counter to zero.
// [RULE6] Two-bit stack index counts up on call, down on return.
// [RULE7] Reset or all-clear zeroes the stack index, selecting top stack word.
// [RULE8] Index 0,1,2,3 selects data words F,E,D,C respectively.
// [RULE9] Stack overflow or underflow raises an internal counter reset.
// [RULE10] Program memory holds 1002 ten-bit words addressed by the counter.
// [RULE11] Data memory of 32 five-bit words, paired for ten-bit access.
// [RULE12] Data memory keeps its contents across reset.
// [RULE13] Table address is pointer pair low eight bits plus control high two.
// [RULE14] Accumulator and table pointer are not initialised by reset.
// [RULE15] Software should not use the table pointer as a branch operand.
// [RULE16] All-clear acts exactly like reset, both sampled on the clock.
module pss_sequencer #(
   parameter int PROG_DEPTH = pss_pkg::PROG_DEPTH,
   parameter logic [pss_pkg::PROG_DEPTH*pss_pkg::PC_W-1:0] PROG_INIT = '0
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic all_clear_i,
   input wire pss_pkg::pss_seq_req_t seq_req_i,
   input wire logic seq_valid_i,
   input wire pss_pkg::pss_dmem_wr_t dmem_wr_i,
   input wire logic [pss_pkg::DADDR_W-1:0] dmem_raddr_i,
   input wire logic acc_we_i,
   input wire logic [pss_pkg::ACC_W-1:0] acc_d_i,
   input wire logic table_rd_i,
   input wire logic [pss_pkg::TPTR_HI_W-1:0] table_page_i,
   output logic [pss_pkg::PC_W-1:0] program_counter_o,
   output logic [pss_pkg::SIDX_W-1:0] stack_index_o,
   output logic [pss_pkg::PC_W-1:0] instr_o,
   output logic [pss_pkg::PC_W-1:0] table_data_o,
   output logic [pss_pkg::PC_W-1:0] table_addr_o,
   output logic [pss_pkg::DMEM_W-1:0] dmem_rdata_o,
   output logic [2*pss_pkg::DMEM_W-1:0] dmem_pair_o,
   output logic [pss_pkg::ACC_W-1:0] acc_o,
   output logic runaway_o
);
   // ****************************************************************
   // Storage
   // ****************************************************************
   // Retained memories sit outside the reset state record
   logic [pss_pkg::PC_W-1:0] prog_mem [PROG_DEPTH]; // [RULE10]
   logic [pss_pkg::DMEM_W-1:0] dmem [pss_pkg::DMEM_DEPTH]; // [RULE11]
   pss_pkg::pss_state_t st;
   pss_pkg::pss_state_t next_st;

   logic clr;
   logic stack_we;
   logic [pss_pkg::DADDR_W-1:0] stack_addr;
   logic [pss_pkg::DADDR_W-1:0] pop_addr;
   logic [pss_pkg::PC_W-1:0] stack_wdata;
   logic [pss_pkg::PC_W-1:0] saved_pc;
   logic [pss_pkg::PC_W-1:0] mem_operand;
   logic [pss_pkg::PC_W-1:0] step_pc;
   logic [pss_pkg::TPTR_LO_W-1:0] tptr_low8;

   assign clr = sys_rst_i | all_clear_i; // [RULE16]

   // ****************************************************************
   // Stack addressing
   // ****************************************************************
   // Push goes to the word for the current index; pop reads the word one address above
   always_comb begin
      stack_addr = pss_pkg::STACK_TOP_ADDR
         - pss_pkg::DADDR_W'(st.stack_index); // [RULE8]
      pop_addr = pss_pkg::STACK_TOP_ADDR
         - pss_pkg::DADDR_W'(st.stack_index - pss_pkg::SIDX_STEP); // [RULE8]
   end

   // Each stack word holds only five bits; the counter spans two words
   // so the saved entry is the pair at the stack word and its neighbour
   assign saved_pc = {dmem[pop_addr], dmem[pop_addr ^ pss_pkg::DADDR_W'(1)]};
   assign stack_wdata = st.program_counter + pss_pkg::CALL_SAVE_INC; // [RULE3]
   assign mem_operand = {dmem[seq_req_i.mem_addr ^ pss_pkg::DADDR_W'(1)],
                         dmem[seq_req_i.mem_addr]};
   assign step_pc = st.program_counter
      + pss_pkg::PC_W'(seq_req_i.length); // [RULE1]
   assign tptr_low8 = {dmem[pss_pkg::TPTR_HIGH_ADDR][pss_pkg::TPTR_LO_W/2-1:0],
                       dmem[pss_pkg::TPTR_LOW_ADDR][pss_pkg::TPTR_LO_W/2-1:0]};

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_st = st;
      stack_we = 1'b0;
      next_st.runaway = 1'b0;
      next_st.instr = prog_mem[st.program_counter]; // [RULE10]
      next_st.table_addr = {table_page_i, tptr_low8}; // [RULE13]
      if (table_rd_i) begin
         next_st.table_data = prog_mem[next_st.table_addr]; // [RULE13]
      end
      if (acc_we_i) begin
         next_st.acc = acc_d_i; // [RULE14]
      end
      if (seq_valid_i) begin
         unique case (seq_req_i.op)
            pss_pkg::PSS_OP_NEXT: begin
               next_st.program_counter = step_pc; // [RULE1]
            end
            pss_pkg::PSS_OP_JUMP: begin
               if (seq_req_i.taken) begin
                  next_st.program_counter = (st.program_counter & ~seq_req_i.load_mask)
                     | (seq_req_i.target & seq_req_i.load_mask); // [RULE2]
               end else begin
                  next_st.program_counter = step_pc;
               end
            end
            pss_pkg::PSS_OP_JUMP_MEM: begin
               if (seq_req_i.taken) begin
                  next_st.program_counter = (st.program_counter & ~seq_req_i.load_mask)
                     | (mem_operand & seq_req_i.load_mask); // [RULE2]
               end else begin
                  next_st.program_counter = step_pc;
               end
            end
            pss_pkg::PSS_OP_CALL: begin
               if (st.stack_index == pss_pkg::SIDX_MAX) begin
                  next_st.runaway = 1'b1; // [RULE9]
                  next_st.program_counter = pss_pkg::PC_RESET; // [RULE9]
                  next_st.stack_index = pss_pkg::SIDX_RESET;
               end else begin
                  stack_we = 1'b1; // [RULE3]
                  next_st.program_counter = seq_req_i.target; // [RULE3]
                  next_st.stack_index = st.stack_index + pss_pkg::SIDX_STEP; // [RULE6]
               end
            end
            pss_pkg::PSS_OP_RETURN: begin
               if (st.stack_index == pss_pkg::SIDX_RESET) begin
                  next_st.runaway = 1'b1; // [RULE9]
                  next_st.program_counter = pss_pkg::PC_RESET; // [RULE9]
               end else begin
                  next_st.program_counter = saved_pc + pss_pkg::RET_INC; // [RULE4]
                  next_st.stack_index = st.stack_index - pss_pkg::SIDX_STEP; // [RULE6]
               end
            end
            default: begin
               next_st.program_counter = step_pc;
            end
         endcase
      end
      if (clr) begin
         next_st.program_counter = pss_pkg::PC_RESET; // [RULE5]
         next_st.stack_index = pss_pkg::SIDX_RESET; // [RULE7]
         next_st.runaway = 1'b0;
         next_st.instr = '0;
         next_st.table_data = '0;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // Reset does not load the accumulator or table address; both keep updating from their inputs during reset
   always_ff @(posedge ref_clk_i) begin
      st <= next_st;
   end

   initial begin
      for (int i = 0; i < PROG_DEPTH; i++) begin
         prog_mem[i] = PROG_INIT[i*pss_pkg::PC_W +: pss_pkg::PC_W];
      end
   end

   // Data memory has no reset value; clear only blocks stack pushes
   always_ff @(posedge ref_clk_i) begin
      if (stack_we && !clr) begin
         dmem[stack_addr] <= stack_wdata[pss_pkg::PC_W-1 -: pss_pkg::DMEM_W]; // [RULE3]
         dmem[stack_addr ^ pss_pkg::DADDR_W'(1)] <= stack_wdata[pss_pkg::DMEM_W-1:0]; // [RULE3]
      end else if (dmem_wr_i.we) begin
         dmem[dmem_wr_i.addr] <= dmem_wr_i.data; // [RULE12]
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign program_counter_o = st.program_counter;
   assign stack_index_o = st.stack_index;
   assign instr_o = st.instr;
   assign table_data_o = st.table_data;
   assign table_addr_o = st.table_addr;
   assign acc_o = st.acc;
   assign runaway_o = st.runaway;
   assign dmem_rdata_o = dmem[dmem_raddr_i];
   assign dmem_pair_o = {dmem[dmem_raddr_i ^ pss_pkg::DADDR_W'(1)],
                         dmem[dmem_raddr_i]}; // [RULE11]
endmodule

//--- verif/pss_seq_properties.sv
// Checker: counter and stack properties seen at the sequencer ports
`timescale 1ns/1ps
module pss_seq_properties (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic all_clear_i,
   input wire pss_pkg::pss_seq_req_t seq_req_i,
   input wire logic seq_valid_i,
   input wire logic [pss_pkg::PC_W-1:0] program_counter_o,
   input wire logic [pss_pkg::SIDX_W-1:0] stack_index_o,
   input wire logic runaway_o
);
   wire pss_pkg::pss_seq_req_t rq = seq_req_i;
   wire logic [9:0] pc = program_counter_o;
   wire logic [1:0] si = stack_index_o;
   wire logic call = seq_valid_i && rq.op == pss_pkg::PSS_OP_CALL;
   wire logic ret = seq_valid_i && rq.op == pss_pkg::PSS_OP_RETURN;
   wire logic [9:0] jmp_pc = (pc & ~rq.load_mask) | (rq.target & rq.load_mask);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i || all_clear_i);
   AST_CLEAR: assert property (disable iff (sys_rst_i) all_clear_i
      |=> pc == 10'h000 && si == 2'h0 && !runaway_o) else $error("all-clear left state");
   AST_NEXT: assert property (seq_valid_i && rq.op == pss_pkg::PSS_OP_NEXT
      |=> pc == $past(pc) + 10'($past(rq.length))) else $error("step wrong");
   AST_JUMP: assert property (seq_valid_i && rq.op == pss_pkg::PSS_OP_JUMP && rq.taken
      |=> pc == $past(jmp_pc)) else $error("jump load wrong");
   AST_CALL: assert property (call && si != 2'h3
      |=> pc == $past(rq.target) && si == $past(si) + 2'h1) else $error("call wrong");
   AST_RET: assert property (ret && si != 2'h0 |=> si == $past(si) - 2'h1)
      else $error("return index wrong");
   AST_PAIR: assert property (call && si == 2'h0 ##1 ret
      |=> pc == $past(pc, 2) + 10'h003) else $error("return address wrong");
   AST_OVF: assert property (call && si == 2'h3
      |=> runaway_o && pc == 10'h000 && si == 2'h0) else $error("overflow missed");
   AST_UNF: assert property (ret && si == 2'h0 |=> runaway_o && pc == 10'h000)
      else $error("underflow missed");
endmodule
bind pss_sequencer pss_seq_properties u_props (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
   .all_clear_i(all_clear_i), .seq_req_i(seq_req_i), .seq_valid_i(seq_valid_i),
   .program_counter_o(program_counter_o), .stack_index_o(stack_index_o), .runaway_o(runaway_o));

//--- verif/tb_top.sv
// Testbench: directed scenarios for the program sequencer and stack
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
   logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, all_clear_i = 1'b0, seq_valid_i = 1'b0;
   logic acc_we_i = 1'b0, table_rd_i = 1'b0, runaway_o;
   logic [1:0] table_page_i = 2'h0, stack_index_o;
   logic [3:0] acc_d_i = 4'h0, acc_o;
   logic [4:0] dmem_raddr_i = 5'h00, dmem_rdata_o;
   logic [9:0] program_counter_o, instr_o, table_data_o, table_addr_o, dmem_pair_o;
   pss_pkg::pss_seq_req_t seq_req_i = '0;
   pss_pkg::pss_dmem_wr_t dmem_wr_i = '0;
   int n_fail = 0;
   int total_checks = 0;
   function automatic logic [9:0] rom(int k);
      return 10'(k) ^ 10'h2AA;
   endfunction
   function automatic logic [pss_pkg::PROG_DEPTH*10-1:0] rom_img();
      for (int k = 0; k < pss_pkg::PROG_DEPTH; k++)
         rom_img[k*10 +: 10] = rom(k);
   endfunction
   pss_sequencer #(.PROG_INIT(rom_img())) uut (.ref_clk_i, .sys_rst_i, .all_clear_i, .seq_req_i,
      .seq_valid_i, .dmem_wr_i, .dmem_raddr_i, .acc_we_i, .acc_d_i, .table_rd_i, .table_page_i,
      .program_counter_o, .stack_index_o, .instr_o, .table_data_o, .table_addr_o, .dmem_rdata_o,
      .dmem_pair_o, .acc_o, .runaway_o);
   always #5 ref_clk_i = ~ref_clk_i;
   // Zero mask means a jump not taken
   task automatic req(pss_pkg::pss_op_t op, logic [1:0] len, logic [9:0] tg, logic [9:0] mk);
      @(posedge ref_clk_i);
      seq_req_i <= '{op, len, tg, mk, 5'h04, mk != 10'h000};
      seq_valid_i <= 1'b1;
   endtask
   task automatic idle();
      @(posedge ref_clk_i);
      seq_valid_i <= 1'b0;
      #1;
   endtask
   task automatic wr(logic [4:0] a, logic [4:0] d);
      @(posedge ref_clk_i);
      dmem_wr_i <= '{1'b1, a, d};
      @(posedge ref_clk_i);
      dmem_wr_i <= '0;
   endtask
   task automatic rd(logic [4:0] a);
      @(posedge ref_clk_i);
      dmem_raddr_i <= a;
      #1;
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic t_flow();
      `CHK("pc_rst", 10'h000, program_counter_o)
      `CHK("idx_rst", 2'h0, stack_index_o)
      req(pss_pkg::PSS_OP_NEXT, 2'h2, 10'h000, 10'h000);
      req(pss_pkg::PSS_OP_NEXT, 2'h1, 10'h000, 10'h000);
      req(pss_pkg::PSS_OP_JUMP, 2'h3, 10'h3C5, 10'h000);
      idle();
      `CHK("pc_step", 10'h006, program_counter_o)
      req(pss_pkg::PSS_OP_JUMP, 2'h1, 10'h3C5, 10'h0F0);
      idle();
      `CHK("pc_jump", 10'h0C6, program_counter_o)
      req(pss_pkg::PSS_OP_JUMP, 2'h1, 10'h123, 10'h3FF);
      idle();
      idle();
      `CHK("instr", rom(10'h123), instr_o)
   endtask
   task automatic t_mem();
      wr(5'h04, 5'h0A);
      wr(5'h05, 5'h13);
      rd(5'h04);
      `CHK("rdata", 5'h0A, dmem_rdata_o)
      `CHK("pair", 10'h26A, dmem_pair_o)
      req(pss_pkg::PSS_OP_JUMP_MEM, 2'h1, 10'h000, 10'h3FF);
      idle();
      `CHK("pc_mem", 10'h26A, program_counter_o)
      @(posedge ref_clk_i);
      all_clear_i <= 1'b1;
      @(posedge ref_clk_i);
      all_clear_i <= 1'b0;
      #1;
      `CHK("pc_clr", 10'h000, program_counter_o)
      `CHK("ram_kept", 5'h0A, dmem_rdata_o)
   endtask
   task automatic t_stack();
      req(pss_pkg::PSS_OP_JUMP, 2'h1, 10'h155, 10'h3FF);
      req(pss_pkg::PSS_OP_CALL, 2'h1, 10'h2A0, 10'h3FF);
      idle();
      `CHK("pc_call", 10'h2A0, program_counter_o)
      `CHK("idx_call", 2'h1, stack_index_o)
      rd(5'h0F);
      `CHK("word_f", 5'h0A, dmem_rdata_o)
      rd(5'h0E);
      `CHK("word_e", 5'h16, dmem_rdata_o)
      req(pss_pkg::PSS_OP_RETURN, 2'h1, 10'h000, 10'h3FF);
      req(pss_pkg::PSS_OP_CALL, 2'h1, 10'h2A0, 10'h3FF);
      req(pss_pkg::PSS_OP_RETURN, 2'h1, 10'h000, 10'h3FF);
      idle();
      `CHK("pc_ret", 10'h15B, program_counter_o)
      repeat (3) req(pss_pkg::PSS_OP_CALL, 2'h1, 10'h2A0, 10'h3FF);
      idle();
      `CHK("idx_deep", 2'h3, stack_index_o)
      req(pss_pkg::PSS_OP_CALL, 2'h1, 10'h2A0, 10'h3FF);
      idle();
      `CHK("ovf", 1'b1, runaway_o)
      `CHK("ovf_pc", 10'h000, program_counter_o)
      req(pss_pkg::PSS_OP_RETURN, 2'h1, 10'h000, 10'h3FF);
      idle();
      `CHK("unf", 1'b1, runaway_o)
   endtask
   task automatic t_table();
      wr(5'h00, 5'h05);
      wr(5'h01, 5'h0C);
      @(posedge ref_clk_i);
      table_page_i <= 2'h2;
      acc_we_i <= 1'b1;
      acc_d_i <= 4'h9;
      @(posedge ref_clk_i);
      table_rd_i <= 1'b1;
      acc_we_i <= 1'b0;
      @(posedge ref_clk_i);
      table_rd_i <= 1'b0;
      #1;
      `CHK("taddr", 10'h2C5, table_addr_o)
      `CHK("tdata", rom(10'h2C5), table_data_o)
      `CHK("acc", 4'h9, acc_o)
   endtask
   initial begin
      repeat (16) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      #1;
      t_flow();
      t_mem();
      t_stack();
      t_table();
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      n_fail++;
      stop_test();
   end
endmodule
